// File: periph_if_pkg.sv
/*
 * Shared constants and carriers for the peripheral task/event register bank.
 * Assumes a 32-bit Avalon-MM master with byte addresses and word-aligned access.
 */
package periph_if_pkg;

    // ---------------------------------------------------------------------
    // Address space
    // ---------------------------------------------------------------------
    localparam int unsigned  DATA_W             = 32;
    localparam int unsigned  ADDR_W             = 32;
    localparam int unsigned  ID_W               = 8;
    localparam int unsigned  WINDOW_WORDS       = 1024;
    localparam logic [31:0]  WINDOW_BYTES       = 32'h0000_1000;
    localparam int unsigned  WINDOW_LSB         = 12;
    localparam logic [31:0]  PERIPH_SPACE_BASE  = 32'h4000_0000;

    // ---------------------------------------------------------------------
    // Register offsets inside the window
    // ---------------------------------------------------------------------
    localparam logic [11:0]  OFS_TASKS          = 12'h000;
    localparam logic [11:0]  OFS_EVENTS         = 12'h100;
    localparam logic [11:0]  OFS_SHORTS         = 12'h200;
    localparam logic [11:0]  OFS_IRQ_MASK       = 12'h300;
    localparam logic [11:0]  OFS_IRQ_SET        = 12'h304;
    localparam logic [11:0]  OFS_IRQ_CLR        = 12'h308;
    localparam logic [11:0]  OFS_ENABLE         = 12'h500;
    localparam logic [11:0]  REG_STRIDE         = 12'h004;

    // ---------------------------------------------------------------------
    // Reset values and fields
    // ---------------------------------------------------------------------
    localparam logic [31:0]  RST_WORD           = 32'h0000_0000;
    localparam int unsigned  ENABLE_BIT         = 0;
    localparam int unsigned  TRIGGER_BIT        = 0;
    localparam int unsigned  IRQ_CLEAR_MAX_CYC  = 4;
    localparam int unsigned  MAX_SHORTS         = 32;

    // ---------------------------------------------------------------------
    // Bus carriers
    // ---------------------------------------------------------------------
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } avmm_req_s;

endpackage

// File: setclr_reg.sv
/*
 * Register with a main view, a set alias and a clear alias.
 * Assumes the caller decodes the three addresses and merges byte lanes.
 */
`timescale 1ns/1ps
module setclr_reg
#(
    parameter int unsigned W = 32
)
(
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    input  wire logic         wr_main_i,
    input  wire logic         wr_set_i,
    input  wire logic         wr_clr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] value_o
);
    import periph_if_pkg::*;

    logic [W-1:0] value_q;

    // ---------------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            value_q <= RST_WORD[W-1:0];
        end
        else if (wr_main_i)
        begin
            value_q <= wdata_i;
        end
        else if (wr_set_i)
        begin
            value_q <= value_q | wdata_i;
        end
        else if (wr_clr_i)
        begin
            value_q <= value_q & ~wdata_i;
        end
    end

    assign value_o = value_q;

    // ---------------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------------
    chk_set_alias_ones: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_set_i && !wr_main_i) |=> (value_q == ($past(value_q) | $past(wdata_i))))
        else $error("set alias did not or in written ones");

    chk_clr_alias_ones: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_clr_i && !wr_main_i && !wr_set_i) |=> (value_q == ($past(value_q) & ~$past(wdata_i))))
        else $error("clear alias did not remove written ones");

endmodule

// File: peripheral_task_event_interface.sv
/*
 * Common task, event, shortcut and interrupt register bank of one peripheral,
 * reached over an Avalon-MM slave with one wait state on every access.
 * Assumes task and event pulses come from logic on ref_clk_i.
 */
// Function
// - The peripheral decodes its own aligned 0x1000-byte window of 1024 words.
// - Identifier equals base address minus 0x40000000, divided by 0x1000.
// - Set-and-clear register uses main, set alias, clear alias at consecutive words.
// - Ones written to set or clear alias set or clear bits; zeros do nothing.
// - Reading the set or clear alias returns the main register.
// - A task fires on software write of one or on its input pulse.
// - Event pulse sets the event register; only a written zero clears it.
// - Event pulses still go out while the event register already reads one.
// - An enabled shortcut triggers its fixed task when its event occurs.
// - Shortcut enables sit in one register, one bit each, at most 32.
// - One interrupt line per peripheral, numbered by the peripheral identifier.
// - Each event is separately enabled as interrupt source; several may combine.
// - Each event has the same bit position in mask, set and clear ports.
// - Reading the interrupt set or clear port returns the interrupt mask.
// - The interrupt may stay up at most four cycles after a clear.
`timescale 1ns/1ps
module peripheral_task_event_interface
    import periph_if_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR  = 32'h4000_0000,
    parameter int unsigned NUM_TASKS  = 4,
    parameter int unsigned NUM_EVENTS = 4,
    parameter int unsigned NUM_SHORTS = 4
)
(
    input  wire logic                       ref_clk_i,
    input  wire logic                       rstn_i,
    input  wire periph_if_pkg::avmm_req_s   bus_req_i,
    output logic                            bus_waitrequest_o,
    output logic [periph_if_pkg::DATA_W-1:0] bus_readdata_o,
    input  wire logic [NUM_TASKS-1:0]       task_in_i,
    input  wire logic [NUM_EVENTS-1:0]      event_pulse_i,
    output logic [NUM_TASKS-1:0]            task_o,
    output logic [NUM_EVENTS-1:0]           event_o,
    output logic                            enable_o,
    output logic                            irq_o,
    output logic [periph_if_pkg::ID_W-1:0]  peripheral_id_o
);
    import periph_if_pkg::*;

    // ---------------------------------------------------------------------
    // Identity and decode
    // ---------------------------------------------------------------------
    localparam logic [31:0]   ID_FULL  = (BASE_ADDR - PERIPH_SPACE_BASE) >> WINDOW_LSB;
    localparam logic [ID_W-1:0] PERIPH_ID = ID_FULL[ID_W-1:0];

    logic               ack_q;
    logic               req;
    logic               hit;
    logic [11:0]        ofs;
    logic               wr_fire;
    logic [DATA_W-1:0]  lane_mask;
    logic [DATA_W-1:0]  wdata_m;
    logic [DATA_W-1:0]  rdata_d;
    logic [DATA_W-1:0]  rdata_q;
    logic               enable_q;
    logic [31:0]        shorts_q;
    logic [31:0]        irq_mask;
    logic [31:0]        irq_mask_merged;
    logic [NUM_EVENTS-1:0] event_q;
    logic [NUM_EVENTS-1:0] evt_fire;
    logic [NUM_TASKS-1:0]  task_d;
    logic [NUM_TASKS-1:0]  task_q;
    logic [NUM_EVENTS-1:0] event_out_q;
    logic               irq_q;

    assign req = bus_req_i.read | bus_req_i.write;
    // Only the upper address bits select the window; the low 12 bits pick the word
    assign hit = (bus_req_i.address[ADDR_W-1:WINDOW_LSB] == BASE_ADDR[ADDR_W-1:WINDOW_LSB]);
    assign ofs = {bus_req_i.address[WINDOW_LSB-1:2], 2'b00};
    assign peripheral_id_o = PERIPH_ID;
    assign wr_fire = bus_req_i.write & ack_q & hit;

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            lane_mask[8*b +: 8] = {8{bus_req_i.byteenable[b]}};
        end
    end
    assign wdata_m = bus_req_i.writedata & lane_mask;

    // ---------------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------------
    // One fixed wait state keeps read data registered and timing simple
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end
    assign bus_waitrequest_o = req & ~ack_q;

    // ---------------------------------------------------------------------
    // Enable and shortcut registers
    // ---------------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            enable_q <= RST_WORD[ENABLE_BIT];
        end
        else if (wr_fire && ofs == OFS_ENABLE && bus_req_i.byteenable[0])
        begin
            enable_q <= bus_req_i.writedata[ENABLE_BIT];
        end
    end
    assign enable_o = enable_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            shorts_q <= RST_WORD;
        end
        else if (wr_fire && ofs == OFS_SHORTS)
        begin
            // Bits above the implemented shortcuts stay zero
            shorts_q <= ((shorts_q & ~lane_mask) | wdata_m)
                        & ((32'h0000_0001 << NUM_SHORTS) - 32'h0000_0001);
        end
    end

    // ---------------------------------------------------------------------
    // Interrupt mask with set and clear aliases
    // ---------------------------------------------------------------------
    assign irq_mask_merged = (irq_mask & ~lane_mask) | wdata_m;

    setclr_reg #(
        .W (32)
    ) u_irq_mask (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .wr_main_i (wr_fire && ofs == OFS_IRQ_MASK),
        .wr_set_i  (wr_fire && ofs == OFS_IRQ_SET),
        .wr_clr_i  (wr_fire && ofs == OFS_IRQ_CLR),
        .wdata_i   ((ofs == OFS_IRQ_MASK) ? irq_mask_merged : wdata_m),
        .value_o   (irq_mask)
    );

    // ---------------------------------------------------------------------
    // Per-event and per-task logic
    // ---------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_EVENTS; g++)
        begin : g_event
            localparam logic [11:0] EV_OFS = OFS_EVENTS + 12'(g * 4);
            // Pulses of a disabled peripheral are dropped
            assign evt_fire[g] = enable_q & event_pulse_i[g];

            always_ff @(posedge ref_clk_i)
            begin
                if (!rstn_i)
                begin
                    event_q[g] <= 1'b0;
                end
                else if (evt_fire[g])
                begin
                    // New event beats a simultaneous software clear
                    event_q[g] <= 1'b1;
                end
                else if (wr_fire && ofs == EV_OFS && bus_req_i.byteenable[0]
                         && !bus_req_i.writedata[0])
                begin
                    event_q[g] <= 1'b0;
                end
            end
        end

        for (g = 0; g < NUM_TASKS; g++)
        begin : g_task
            localparam logic [11:0] TK_OFS = OFS_TASKS + 12'(g * 4);
            logic sw_trig;
            logic short_trig;
            assign sw_trig = wr_fire && ofs == TK_OFS && bus_req_i.byteenable[0]
                             && bus_req_i.writedata[TRIGGER_BIT];
            // Shortcut g links event g to task g
            if (g < NUM_SHORTS && g < NUM_EVENTS)
            begin : g_short
                assign short_trig = shorts_q[g] & evt_fire[g];
            end
            else
            begin : g_noshort
                assign short_trig = 1'b0;
            end
            assign task_d[g] = enable_q & (sw_trig | task_in_i[g] | short_trig);
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            task_q <= '0;
        end
        else
        begin
            task_q <= task_d;
        end
    end
    assign task_o = task_q;

    // Outgoing pulses do not look at the sticky register
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            event_out_q <= '0;
        end
        else
        begin
            event_out_q <= evt_fire;
        end
    end
    assign event_o = event_out_q;

    // ---------------------------------------------------------------------
    // Interrupt line
    // ---------------------------------------------------------------------
    // One register stage after the mask: a clear reaches irq_o two cycles after the write, inside the allowed four
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(event_q & irq_mask[NUM_EVENTS-1:0]);
        end
    end
    assign irq_o = irq_q;

    // ---------------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------------
    always_comb
    begin
        rdata_d = RST_WORD;
        if (hit)
        begin
            if (ofs == OFS_IRQ_MASK || ofs == OFS_IRQ_SET || ofs == OFS_IRQ_CLR)
            begin
                rdata_d = irq_mask;
            end
            else if (ofs == OFS_SHORTS)
            begin
                rdata_d = shorts_q;
            end
            else if (ofs == OFS_ENABLE)
            begin
                rdata_d[ENABLE_BIT] = enable_q;
            end
            for (int i = 0; i < NUM_EVENTS; i++)
            begin
                if (ofs == OFS_EVENTS + 12'(i * 4))
                begin
                    rdata_d[0] = event_q[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= RST_WORD;
        end
        else if (bus_req_i.read && !ack_q)
        begin
            rdata_q <= rdata_d;
        end
    end
    assign bus_readdata_o = rdata_q;

    // ---------------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------------
    sequence s_read_take;
        bus_req_i.read && !ack_q;
    endsequence

    sequence s_read_done;
        ##1 (ack_q && !bus_waitrequest_o);
    endsequence

    chk_access_one_wait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_read_take |-> s_read_done)
        else $error("read not answered after exactly one wait state");

    chk_alias_read_mask: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (s_read_take ##0 (hit && (ofs == OFS_IRQ_SET || ofs == OFS_IRQ_CLR)))
        |=> (bus_readdata_o == $past(irq_mask)))
        else $error("set or clear alias read did not return the mask");

    chk_id_from_base: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        peripheral_id_o == ID_W'((BASE_ADDR - PERIPH_SPACE_BASE) / WINDOW_BYTES))
        else $error("identifier does not follow base address");

    chk_foreign_no_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (bus_req_i.write && ack_q && !hit) |=> $stable(shorts_q) && $stable(enable_q))
        else $error("write outside the window changed state");

    chk_event_sticky: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (event_q[0] && !(wr_fire && ofs == OFS_EVENTS)) |=> event_q[0])
        else $error("event register dropped without a written zero");

    chk_event_pulse_out: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (enable_q && event_pulse_i[0] && event_q[0]) |=> event_o[0])
        else $error("event pulse suppressed while register was set");

    chk_shortcut_task: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (enable_q && shorts_q[0] && event_pulse_i[0]) |=> task_o[0])
        else $error("shortcut did not trigger its task");

    chk_disabled_quiet: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !enable_q |=> (task_o == '0) && (event_o == '0))
        else $error("disabled peripheral produced a pulse");

    chk_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (|(event_q & irq_mask[NUM_EVENTS-1:0])) |=> irq_o)
        else $error("interrupt not raised for enabled pending event");

    chk_irq_drop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (irq_o && ((wr_fire && ofs == OFS_IRQ_CLR && bus_req_i.writedata == 32'hFFFF_FFFF
                    && bus_req_i.byteenable == 4'hF)))
        |-> ##[1:4] !irq_o)
        else $error("interrupt stayed up past the clear latency");

endmodule

// File: interconnect_model.sv
/*
 * Far-side model: the interconnect and the peripheral core that pulse
 * task and event lines of the register bank.
 * Assumes its task is entered just after a rising edge of ref_clk_i.
 */
`timescale 1ns/1ps
module interconnect_model
#(
    parameter int unsigned NT = 4,
    parameter int unsigned NE = 4
)
(
    input  wire logic          ref_clk_i,
    output logic      [NT-1:0] task_in_o,
    output logic      [NE-1:0] event_pulse_o
);
    // ---------------------------------------------------------------------
    // Pulse driver
    // ---------------------------------------------------------------------
    initial
    begin
        task_in_o     = '0;
        event_pulse_o = '0;
    end

    // One-cycle pulses only; a removed link is a line that never pulses
    task automatic pulse(input logic [NT-1:0] t, input logic [NE-1:0] e);
        task_in_o     <= t;
        event_pulse_o <= e;
        @(posedge ref_clk_i);
        task_in_o     <= '0;
        event_pulse_o <= '0;
    endtask
endmodule

// File: tb_peripheral_task_event_interface.sv
/*
 * Self-checking bench for the peripheral task/event register bank.
 * Assumes one 250 MHz clock and the far-side model in interconnect_model.
 */
`timescale 1ns/1ps
module tb_peripheral_task_event_interface;
    import periph_if_pkg::*;
    // ---------------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------------
    localparam logic [31:0] BASE   = 32'h4001_F000;
    localparam logic [31:0] EXP_ID = (BASE - PERIPH_SPACE_BASE) >> WINDOW_LSB;
    logic             ref_clk_i = 1'b0;
    logic             rstn_i;
    avmm_req_s        req;
    logic             bus_waitrequest_o;
    logic [31:0]      bus_readdata_o;
    logic [3:0]       task_in;
    logic [3:0]       ev_in;
    logic [3:0]       task_o;
    logic [3:0]       event_o;
    logic             enable_o;
    logic             irq_o;
    logic [7:0]       peripheral_id_o;
    int               bad_count = 0;
    int               compares = 0;
    int               task_cnt [4] = '{0, 0, 0, 0};
    int               ev_cnt [4] = '{0, 0, 0, 0};

    always #2 ref_clk_i = ~ref_clk_i;

    peripheral_task_event_interface #(.BASE_ADDR(BASE)) peripheral_task_event_interface_i
    (
        .ref_clk_i         (ref_clk_i),
        .rstn_i            (rstn_i),
        .bus_req_i         (req),
        .bus_waitrequest_o (bus_waitrequest_o),
        .bus_readdata_o    (bus_readdata_o),
        .task_in_i         (task_in),
        .event_pulse_i     (ev_in),
        .task_o            (task_o),
        .event_o           (event_o),
        .enable_o          (enable_o),
        .irq_o             (irq_o),
        .peripheral_id_o   (peripheral_id_o)
    );

    interconnect_model interconnect_model_i
    (
        .ref_clk_i     (ref_clk_i),
        .task_in_o     (task_in),
        .event_pulse_o (ev_in)
    );

    // Pulses counted on the falling edge, clear of the launching edge
    always @(negedge ref_clk_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            task_cnt[i] += int'(task_o[i] === 1'b1);
            ev_cnt[i] += int'(event_o[i] === 1'b1);
        end
    end

    // ---------------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------------
    function automatic logic [31:0] at(input logic [11:0] ofs);
        return BASE + {20'h00000, ofs};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        int n;
        n = 0;
        req.address   <= a;
        req.writedata <= d;
        req.write     <= w;
        req.read      <= !w;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (bus_waitrequest_o !== 1'b0 && n < 50);
        rd = bus_readdata_o;
        chk(32'(n < 50), 32'h1, "bus answer");
        req.write <= 1'b0;
        req.read  <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string s);
        logic [31:0] rd;
        xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp, s);
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------------
    initial
    begin
        #80000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        req = '0;
        req.byteenable = 4'hF;
        rstn_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        chk({24'h0, peripheral_id_o}, EXP_ID, "identifier");
        rd_chk(at(OFS_ENABLE), 32'h0, "enable reset");
        rd_chk(at(OFS_IRQ_MASK), 32'h0, "mask reset");
        rd_chk(at(OFS_SHORTS), 32'h0, "shorts reset");
        interconnect_model_i.pulse(4'h2, 4'h1);
        wr(at(OFS_TASKS + REG_STRIDE), 32'h1);
        repeat (2) @(posedge ref_clk_i);
        rd_chk(at(OFS_EVENTS), 32'h0, "event while disabled");
        chk(32'(ev_cnt[0] + task_cnt[1]), 32'h0, "pulses while disabled");
        $display("test disabled done");
        // Configuration first, enable last
        wr(at(OFS_SHORTS), 32'h1);
        wr(at(OFS_IRQ_SET), 32'h5);
        rd_chk(at(OFS_IRQ_MASK), 32'h5, "mask after set");
        rd_chk(at(OFS_IRQ_SET), 32'h5, "set port read");
        rd_chk(at(OFS_IRQ_CLR), 32'h5, "clear port read");
        wr(at(OFS_IRQ_CLR), 32'h1);
        wr(at(OFS_IRQ_SET), 32'h0);
        rd_chk(at(OFS_IRQ_MASK), 32'h4, "mask after clear");
        wr(at(OFS_IRQ_SET), 32'h2);
        rd_chk(at(OFS_IRQ_CLR), 32'h6, "mask bit positions");
        wr(at(OFS_ENABLE), 32'h1);
        rd_chk(at(OFS_ENABLE), 32'h1, "enable read");
        chk(32'(enable_o), 32'h1, "enable out");
        $display("test config done");
        wr(at(OFS_TASKS + (REG_STRIDE << 1)), 32'h1);
        wr(at(OFS_TASKS + REG_STRIDE), 32'h0);
        interconnect_model_i.pulse(4'h8, 4'h0);
        repeat (2) @(posedge ref_clk_i);
        chk(32'(task_cnt[2]), 32'h1, "task by write");
        chk(32'(task_cnt[1]), 32'h0, "task by zero write");
        chk(32'(task_cnt[3]), 32'h1, "task by input");
        $display("test tasks done");
        interconnect_model_i.pulse(4'h0, 4'h4);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h1, "irq on event");
        interconnect_model_i.pulse(4'h0, 4'h4);
        wr(at(OFS_EVENTS + (REG_STRIDE << 1)), 32'h1);
        rd_chk(at(OFS_EVENTS + (REG_STRIDE << 1)), 32'h1, "event sticky");
        chk(32'(ev_cnt[2]), 32'h2, "repeat event pulse");
        interconnect_model_i.pulse(4'h0, 4'h8);
        wr(at(OFS_EVENTS + (REG_STRIDE << 1)), 32'h0);
        repeat (4) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h0, "irq after event clear");
        wr(at(OFS_IRQ_SET), 32'h8);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h1, "irq after mask set");
        wr(at(OFS_IRQ_CLR), 32'h8);
        rd_chk(at(OFS_IRQ_CLR), 32'h6, "clear port read back");
        chk(32'(irq_o), 32'h0, "irq after mask clear");
        $display("test events done");
        interconnect_model_i.pulse(4'h0, 4'h1);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(task_cnt[0]), 32'h1, "shortcut fires");
        wr(at(OFS_SHORTS), 32'h0);
        interconnect_model_i.pulse(4'h0, 4'h1);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(task_cnt[0]), 32'h1, "shortcut off");
        $display("test shortcut done");
        rd_chk(at(12'h400), 32'h0, "unmapped read");
        wr(BASE + WINDOW_BYTES + 32'(OFS_IRQ_SET), 32'hF);
        rd_chk(at(OFS_IRQ_MASK), 32'h6, "outside window");
        $display("test decode done");
        // Only this one peripheral is ever enabled on its identifier
        wr(at(OFS_IRQ_SET), 32'h1);
        repeat (2) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h1, "irq from shortcut event");
        wr(at(OFS_ENABLE), 32'h0);
        wr(at(OFS_IRQ_CLR), 32'hFFFF_FFFF);
        rd_chk(at(OFS_IRQ_SET), 32'h0, "mask all clear");
        wr(at(OFS_EVENTS), 32'h0);
        interconnect_model_i.pulse(4'h0, 4'h4);
        repeat (3) @(posedge ref_clk_i);
        rd_chk(at(OFS_EVENTS + (REG_STRIDE << 1)), 32'h0, "no event after off");
        chk({30'h0, enable_o, irq_o}, 32'h0, "off state");
        $display("test switch done");
        give_verdict();
    end
endmodule
